// [design/dmpl_pkg.sv]
// Constants, types and helpers for the data memory parameter loader
// ============================================================
package dmpl_pkg;
  // ============================================================
  // Memory map (word indices, decimal in comments)
  localparam int DM_WORDS = 2000;
  localparam logic [10:0] GEN0_LAST = 11'h383;     // 0899
  localparam logic [10:0] PARAM_BASE = 11'h384;    // 0900
  localparam logic [10:0] PARAM_SUM_ADDR = 11'h3a2; // 0930
  localparam logic [10:0] SYS0_LAST = 11'h3e7;     // 0999
  localparam logic [10:0] GEN1_BASE = 11'h3e8;     // 1000
  localparam logic [10:0] BKUP_BASE = 11'h76c;     // 1900
  localparam logic [10:0] BKUP_SUM_ADDR = 11'h78a; // 1930
  localparam logic [10:0] BKUP_VALID_ADDR = 11'h78b; // 1931
  localparam logic [10:0] DM_LAST = 11'h7cf;       // 1999
  localparam logic [10:0] PARAM_LAST_IDX = 11'h01d; // 30 words
  localparam logic [15:0] VALID_MARK = 16'h0001;
  localparam logic [15:0] PARAM_DEFAULT = 16'h0000;
  localparam logic [7:0] PARAM_HI_MAX = 8'h02;
  // ============================================================
  // Commands and results
  localparam logic [3:0] CMD_APPLY = 4'h1;
  localparam logic [3:0] CMD_BACKUP = 4'h2;
  localparam logic [3:0] CMD_DISABLE = 4'h3;
  localparam logic [3:0] CMD_CLEAR = 4'h4;
  localparam logic [3:0] CMD_RELOAD = 4'h5;
  localparam logic [3:0] CMD_RESTORE = 4'h6;
  localparam logic [3:0] CMD_RESUM = 4'h7;
  localparam logic [7:0] RES_OK = 8'h80;
  localparam logic [7:0] RES_FAIL = 8'h40;
  localparam logic [7:0] FAL_PARAM = 8'h9f;
  localparam int CMD_EXEC_BIT = 15;
  // ============================================================
  // APB register offsets and status bits
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_DM_ADDR = 12'h008;
  localparam logic [11:0] REG_DM_DATA = 12'h00c;
  localparam logic [11:0] REG_CLEAR = 12'h010;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BKVALID = 1;
  localparam int STAT_CSERR = 2;
  localparam int STAT_LASTFAIL = 3;
  // ============================================================
  // Types
  typedef enum {
    ST_IDLE, ST_SUM_B, ST_COPY, ST_SUM_P, ST_APPLY, ST_BACKUP,
    ST_MARK, ST_CLEAR_P, ST_DCLEAR, ST_FINISH
  } dmpl_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic bit_op;
    logic shift_op;
    logic [10:0] addr;
    logic [15:0] wdata;
  } dmpl_req_t;
  typedef struct packed {
    logic done;
    logic error;
    logic [15:0] rdata;
  } dmpl_rsp_t;
  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } dmpl_sys_t;
  typedef logic [29:0][15:0] dmpl_settings_t;
  // ============================================================
  // Helpers
  // BCD word to index; bit 11 set when not a legal address
  function automatic logic [11:0] dmpl_bcd_idx(input logic [15:0] w);
    int v;
    logic bad;
    v = int'(w[15:12]) * 1000 + int'(w[11:8]) * 100 +
        int'(w[7:4]) * 10 + int'(w[3:0]);
    bad = (w[15:12] > 4'h9) || (w[11:8] > 4'h9) ||
          (w[7:4] > 4'h9) || (w[3:0] > 4'h9) || (v >= DM_WORDS);
    return bad ? 12'h800 : {1'b0, v[10:0]};
  endfunction
  function automatic logic dmpl_sys_word(input logic [10:0] a);
    return ((a >= PARAM_BASE) && (a <= SYS0_LAST)) || (a >= BKUP_BASE);
  endfunction
  function automatic logic [15:0] dmpl_check(input logic [15:0] w);
    return (w[15:8] <= PARAM_HI_MAX) ? w : PARAM_DEFAULT;
  endfunction
endpackage

// [design/dmpl_loader.sv]
// Data memory with parameter set-up sequencer and APB access
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dmpl_loader (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB slave, programming device side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // User program operand port
  input dmpl_pkg::dmpl_req_t usr_req,
  output logic usr_ready,
  output dmpl_pkg::dmpl_rsp_t usr_rsp,
  // Set-system instruction
  input dmpl_pkg::dmpl_sys_t set_system_instruction,
  output logic sys_ready,
  // Memory unit state
  input wire logic mem_writable,
  // Settings towards the system
  output dmpl_pkg::dmpl_settings_t settings,
  output logic settings_applied,
  output logic parameter_checksum_error_flag,
  output logic [7:0] failure_alarm_code,
  output logic busy
);
  import dmpl_pkg::*;

  // ============================================================
  // Storage
  // No reset on the array: contents are kept across power loss
  logic [15:0] data_memory [0:DM_WORDS-1];

  dmpl_state_t state_q;
  logic [10:0] idx_q;
  logic [15:0] sum_q;
  logic [3:0] op_q;
  logic from_word_q;
  logic dflt_q;
  logic fail_q;
  logic fin_we_q;
  logic [10:0] fin_addr_q;
  logic [15:0] fin_data_q;
  logic [15:0] mark_q;
  logic [15:0] cmd_q;
  logic [10:0] dm_addr_q;
  logic dclr_pend_q;
  logic lastfail_q;
  logic alarm_q;
  logic [7:0] fal_q;
  logic ack_q;
  logic [31:0] prdata_q;
  dmpl_rsp_t rsp_q;
  dmpl_settings_t settings_q;
  logic applied_q;

  // ============================================================
  // Sequencer datapath
  wire idle = (state_q == ST_IDLE);
  wire last = (idx_q == PARAM_LAST_IDX);
  wire [10:0] p_addr = PARAM_BASE + idx_q;
  wire [10:0] b_addr = BKUP_BASE + idx_q;
  wire [15:0] p_word = data_memory[p_addr];
  wire [15:0] b_word = data_memory[b_addr];
  wire from_bkup = (state_q == ST_SUM_B) || (state_q == ST_COPY);
  wire [15:0] src_word = from_bkup ? b_word : p_word;
  wire [15:0] sum_nxt = sum_q + src_word;
  wire bk_marked = (data_memory[BKUP_VALID_ADDR] == VALID_MARK);
  wire bk_sum_ok = (sum_nxt == data_memory[BKUP_SUM_ADDR]);
  wire p_sum_ok = (sum_nxt == data_memory[PARAM_SUM_ADDR]);

  // ============================================================
  // APB decode; one wait state so read data comes from a flop
  wire apb_acc = psel && penable;
  wire apb_fire = apb_acc && ack_q;
  wire sel_cmd = (paddr == REG_CMD);
  wire sel_stat = (paddr == REG_STAT);
  wire sel_addr = (paddr == REG_DM_ADDR);
  wire sel_data = (paddr == REG_DM_DATA);
  wire sel_clr = (paddr == REG_CLEAR);
  wire mapped = sel_cmd || sel_stat || sel_addr || sel_data || sel_clr;
  wire dm_in_range = (dm_addr_q <= DM_LAST);
  // Backup words and their checksum only move under the sequencer
  wire dm_guarded = (dm_addr_q >= BKUP_BASE) &&
                    (dm_addr_q <= BKUP_VALID_ADDR);
  wire dm_wr_bad = pwrite && (!idle || dm_guarded);
  wire apb_err = !mapped || (sel_data && (!dm_in_range || dm_wr_bad));
  wire apb_wr = apb_fire && pwrite && !apb_err;
  wire apb_dm_wr = apb_wr && sel_data;
  wire [15:0] dm_rd = dm_in_range ? data_memory[dm_addr_q] : 16'h0000;
  wire [15:0] stat_word = {fal_q, 4'h0, lastfail_q, alarm_q,
                           bk_marked, !idle};
  wire [15:0] rd_mux = sel_cmd ? cmd_q :
                       sel_stat ? stat_word :
                       sel_addr ? {5'h00, dm_addr_q} :
                       sel_data ? dm_rd : 16'h0000;

  // ============================================================
  // Command sources; the word source wins over the instruction
  wire [3:0] word_code = cmd_q[11:8];
  wire code_ok = (word_code >= CMD_APPLY) && (word_code <= CMD_RESUM);
  wire cmd_go = idle && cmd_q[CMD_EXEC_BIT] && code_ok &&
                (cmd_q[7:0] == 8'h00);
  wire sys_code_ok = (set_system_instruction.code >= CMD_APPLY) &&
                     (set_system_instruction.code <= CMD_RESUM);
  wire sys_go = idle && !cmd_go && set_system_instruction.valid &&
                sys_code_ok;
  wire start = cmd_go || sys_go;
  wire [3:0] start_code = cmd_go ? word_code : set_system_instruction.code;
  wire dclr_go = idle && !start && dclr_pend_q;

  // ============================================================
  // User operand path
  wire [10:0] u_addr = usr_req.addr;
  wire u_addr_ok = (u_addr <= DM_LAST);
  wire [15:0] u_ptr = u_addr_ok ? data_memory[u_addr] : 16'h0000;
  wire [11:0] u_ind = dmpl_bcd_idx(u_ptr);
  wire [10:0] u_eff = usr_req.indirect ? u_ind[10:0] : u_addr;
  wire u_bad_mode = usr_req.bit_op || usr_req.shift_op;
  wire u_bad_addr = !u_addr_ok || (usr_req.indirect && u_ind[11]);
  wire u_ro = usr_req.write && (u_eff >= GEN1_BASE);
  wire u_err = u_bad_mode || u_bad_addr || u_ro;
  wire u_fire = usr_req.valid && usr_ready;
  wire u_we = u_fire && usr_req.write && !u_err;

  // ============================================================
  // Single write port: sequencer, then APB, then user
  logic mem_we;
  logic [10:0] mem_wa;
  logic [15:0] mem_wd;
  always_comb begin
    mem_we = 1'b0;
    mem_wa = idx_q;
    mem_wd = 16'h0000;
    unique case (state_q)
      ST_COPY: begin
        mem_we = 1'b1;
        mem_wa = p_addr;
        mem_wd = b_word;
      end
      ST_BACKUP: begin
        mem_we = 1'b1;
        mem_wa = b_addr;
        mem_wd = p_word;
      end
      ST_CLEAR_P: begin
        mem_we = 1'b1;
        mem_wa = p_addr;
      end
      ST_DCLEAR: begin
        mem_we = !dmpl_sys_word(idx_q);
        mem_wa = idx_q;
      end
      ST_MARK: begin
        mem_we = 1'b1;
        mem_wa = BKUP_VALID_ADDR;
        mem_wd = mark_q;
      end
      ST_FINISH: begin
        mem_we = fin_we_q;
        mem_wa = fin_addr_q;
        mem_wd = fin_data_q;
      end
      ST_IDLE: begin
        if (apb_dm_wr) begin
          mem_we = 1'b1;
          mem_wa = dm_addr_q;
          mem_wd = pwdata[15:0];
        end else if (u_we) begin
          mem_we = 1'b1;
          mem_wa = u_eff;
          mem_wd = usr_req.wdata;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (clk_en && mem_we) begin
      data_memory[mem_wa] <= mem_wd;
    end
  end

  // ============================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_SUM_B; // power-on load
      op_q <= CMD_RELOAD;
      from_word_q <= 1'b0;
      idx_q <= 11'h000;
      sum_q <= 16'h0000;
      dflt_q <= 1'b0;
      fail_q <= 1'b0;
      fin_we_q <= 1'b0;
      fin_addr_q <= 11'h000;
      fin_data_q <= 16'h0000;
      mark_q <= 16'h0000;
    end else if (clk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= 11'h000;
          sum_q <= 16'h0000;
          dflt_q <= 1'b0;
          fail_q <= 1'b0;
          fin_we_q <= 1'b0;
          if (start) begin
            op_q <= start_code;
            from_word_q <= cmd_go;
            unique case (start_code)
              CMD_APPLY: state_q <= ST_APPLY;
              CMD_BACKUP: begin
                // Protected or one-time memory refuses the backup
                if (mem_writable) begin
                  state_q <= ST_BACKUP;
                end else begin
                  fail_q <= 1'b1;
                  state_q <= ST_FINISH;
                end
              end
              CMD_DISABLE: begin
                mark_q <= 16'h0000;
                state_q <= ST_MARK;
              end
              CMD_CLEAR: state_q <= ST_CLEAR_P;
              CMD_RELOAD: state_q <= ST_SUM_B;
              CMD_RESTORE: state_q <= ST_COPY;
              default: state_q <= ST_SUM_P;
            endcase
          end else if (dclr_go) begin
            op_q <= 4'h0;
            from_word_q <= 1'b0;
            state_q <= ST_DCLEAR;
          end
        end
        ST_SUM_B: begin
          sum_q <= sum_nxt;
          idx_q <= idx_q + 11'h001;
          if (last) begin
            idx_q <= 11'h000;
            sum_q <= 16'h0000;
            if (bk_marked && bk_sum_ok) begin
              state_q <= ST_COPY;
            end else if (bk_marked) begin
              dflt_q <= 1'b1;
              fail_q <= 1'b1;
              state_q <= ST_APPLY;
            end else begin
              state_q <= ST_SUM_P;
            end
          end
        end
        ST_COPY: begin
          sum_q <= sum_nxt;
          idx_q <= idx_q + 11'h001;
          if (last) begin
            idx_q <= 11'h000;
            sum_q <= 16'h0000;
            fin_we_q <= 1'b1;
            fin_addr_q <= PARAM_SUM_ADDR;
            fin_data_q <= sum_nxt;
            state_q <= (op_q == CMD_RESTORE) ? ST_FINISH : ST_APPLY;
          end
        end
        ST_SUM_P: begin
          sum_q <= sum_nxt;
          idx_q <= idx_q + 11'h001;
          if (last) begin
            idx_q <= 11'h000;
            sum_q <= 16'h0000;
            if (op_q == CMD_RESUM) begin
              fin_we_q <= 1'b1;
              fin_addr_q <= PARAM_SUM_ADDR;
              fin_data_q <= sum_nxt;
              state_q <= ST_FINISH;
            end else begin
              // Mismatch: nothing from the area is used
              dflt_q <= !p_sum_ok;
              fail_q <= !p_sum_ok;
              state_q <= ST_APPLY;
            end
          end
        end
        ST_APPLY: begin
          sum_q <= sum_nxt;
          idx_q <= idx_q + 11'h001;
          if (last) begin
            // Fresh sum only when the area itself was applied
            fin_we_q <= !dflt_q;
            fin_addr_q <= PARAM_SUM_ADDR;
            fin_data_q <= sum_nxt;
            state_q <= ST_FINISH;
          end
        end
        ST_BACKUP: begin
          sum_q <= sum_nxt;
          idx_q <= idx_q + 11'h001;
          if (last) begin
            fin_we_q <= 1'b1;
            fin_addr_q <= BKUP_SUM_ADDR;
            fin_data_q <= sum_nxt;
            mark_q <= VALID_MARK;
            state_q <= ST_MARK;
          end
        end
        ST_MARK: state_q <= ST_FINISH;
        ST_CLEAR_P: begin
          idx_q <= idx_q + 11'h001;
          if (last) begin
            state_q <= ST_FINISH;
          end
        end
        ST_DCLEAR: begin
          idx_q <= idx_q + 11'h001;
          if (idx_q == DM_LAST) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Applied settings, checked word by word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settings_q <= '0;
    end else if (clk_en && state_q == ST_APPLY) begin
      settings_q[idx_q[4:0]] <= dflt_q ? PARAM_DEFAULT
                                       : dmpl_check(p_word);
    end
  end

  // ============================================================
  // Command word, status and alarm
  wire finish = clk_en && (state_q == ST_FINISH);
  wire was_apply = (op_q == CMD_APPLY) || (op_q == CMD_RELOAD);
  wire [7:0] result = fail_q && !was_apply ? RES_FAIL : RES_OK;
  wire alarm_set = finish && fail_q && was_apply;
  wire alarm_clr = apb_wr && sel_stat && pwdata[STAT_CSERR];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= 16'h0000;
      dm_addr_q <= 11'h000;
      dclr_pend_q <= 1'b0;
      lastfail_q <= 1'b0;
      alarm_q <= 1'b0;
      fal_q <= 8'h00;
      applied_q <= 1'b0;
    end else if (clk_en) begin
      applied_q <= finish && was_apply;
      if (apb_wr && sel_cmd) begin
        cmd_q[15:8] <= pwdata[15:8];
      end
      // Completion status wins over a clearing write
      if (finish && from_word_q) begin
        cmd_q[7:0] <= result;
      end else if (apb_wr && sel_cmd && !pwdata[CMD_EXEC_BIT]) begin
        cmd_q[7:0] <= 8'h00;
      end
      if (apb_wr && sel_addr) begin
        dm_addr_q <= pwdata[10:0];
      end
      if (apb_wr && sel_clr && pwdata[0]) begin
        dclr_pend_q <= 1'b1;
      end else if (dclr_go) begin
        dclr_pend_q <= 1'b0;
      end
      if (finish) begin
        lastfail_q <= fail_q;
      end
      if (alarm_set) begin
        alarm_q <= 1'b1;
        fal_q <= FAL_PARAM;
      end else if (alarm_clr) begin
        alarm_q <= 1'b0;
        fal_q <= 8'h00;
      end
    end
  end

  // ============================================================
  // Bus and user answers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      rsp_q <= '0;
    end else if (clk_en) begin
      ack_q <= apb_acc && !ack_q;
      if (apb_acc && !ack_q) begin
        prdata_q <= {16'h0000, rd_mux};
      end
      rsp_q.done <= u_fire;
      rsp_q.error <= u_fire && u_err;
      if (u_fire && !usr_req.write && !u_err) begin
        rsp_q.rdata <= data_memory[u_eff];
      end
    end
  end

  assign pready = ack_q;
  assign pslverr = ack_q && apb_err;
  assign prdata = prdata_q;
  assign usr_ready = idle && !apb_dm_wr;
  assign usr_rsp = rsp_q;
  assign sys_ready = idle && !cmd_go;
  assign settings = settings_q;
  assign settings_applied = applied_q;
  assign parameter_checksum_error_flag = alarm_q;
  assign failure_alarm_code = fal_q;
  assign busy = !idle;
endmodule // dmpl_loader

// [tb/dmpl_properties.sv]
// Concurrent checks on the loader's top-level ports
`timescale 1ns/1ps
module dmpl_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Operand and instruction ports
  input dmpl_pkg::dmpl_req_t usr_req,
  input wire logic usr_ready,
  input dmpl_pkg::dmpl_rsp_t usr_rsp,
  input dmpl_pkg::dmpl_sys_t set_system_instruction,
  input wire logic sys_ready,
  // Settings side
  input dmpl_pkg::dmpl_settings_t settings,
  input wire logic settings_applied,
  input wire logic parameter_checksum_error_flag,
  input wire logic [7:0] failure_alarm_code,
  input wire logic busy
);
  import dmpl_pkg::*;
  logic usr_take;
  logic sys_take;
  assign usr_take = usr_req.valid && usr_ready && clk_en;
  assign sys_take = set_system_instruction.valid && sys_ready && clk_en &&
    (set_system_instruction.code inside {[4'h1:4'h7]});
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ========
  // Operand port
  property p_usr_done;
    usr_take |=> usr_rsp.done;
  endproperty
  a_usr_done: assert property (p_usr_done)
    else $error("operand request not answered");
  property p_bit_err;
    usr_take && (usr_req.bit_op || usr_req.shift_op) |=> usr_rsp.error;
  endproperty
  a_bit_err: assert property (p_bit_err)
    else $error("bit or shift operand accepted");
  property p_ro_write;
    usr_take && usr_req.write && !usr_req.indirect &&
      usr_req.addr >= GEN1_BASE |=> usr_rsp.error;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write above word 999 accepted");
  property p_range;
    usr_take && usr_req.addr > DM_LAST |=> usr_rsp.done && usr_rsp.error;
  endproperty
  a_range: assert property (p_range)
    else $error("address beyond memory accepted");
  // ========
  // Sequencer
  property p_busy_block;
    busy |-> !usr_ready && !sys_ready;
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("request accepted while busy");
  property p_sys_start;
    sys_take |=> busy;
  endproperty
  a_sys_start: assert property (p_sys_start)
    else $error("instruction did not start a command");
  property p_alarm;
    failure_alarm_code == (parameter_checksum_error_flag ? FAL_PARAM : 8'h00);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm code disagrees with checksum flag");
  property p_applied;
    settings_applied |-> !busy ##1 !settings_applied;
  endproperty
  a_applied: assert property (p_applied)
    else $error("applied pulse malformed");
  // Settings move only while a load or apply runs
  property p_settings_hold;
    $changed(settings) |-> $past(busy);
  endproperty
  a_settings_hold: assert property (p_settings_hold)
    else $error("settings changed while idle");
endmodule // dmpl_properties

bind dmpl_loader dmpl_properties dmpl_properties_inst (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .usr_req(usr_req),
  .usr_ready(usr_ready), .usr_rsp(usr_rsp), .sys_ready(sys_ready),
  .set_system_instruction(set_system_instruction), .settings(settings),
  .settings_applied(settings_applied), .busy(busy),
  .parameter_checksum_error_flag(parameter_checksum_error_flag),
  .failure_alarm_code(failure_alarm_code)
);

// [tb/dmpl_prog_dev.sv]
// Programming device model: APB master and command word operator
`timescale 1ns/1ps
module dmpl_prog_dev (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import dmpl_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // ========
  // One transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // ========
  // Command word: execute plus code, wait for result, drop execute
  task automatic run_cmd(input logic [3:0] code, output logic [31:0] w);
    logic [31:0] t;
    logic e;
    int n;
    n = 0;
    xfer(1'b1, REG_CMD, {16'h0000, 1'b1, 3'h0, code, 8'h00}, t, e);
    do begin
      xfer(1'b0, REG_CMD, 32'h0, w, e);
      n++;
    end while (w[7:0] === 8'h00 && n < 500);
    xfer(1'b1, REG_CMD, 32'h0, t, e);
  endtask
endmodule // dmpl_prog_dev

// [tb/tb.sv]
// Self-checking bench for the data memory parameter loader
`timescale 1ns/1ps
module tb;
  import dmpl_pkg::*;
  typedef struct {
    logic wr, ind, bop, sop;
    logic [10:0] addr;
    logic [15:0] wd;
    logic err;
    logic [15:0] rd;
  } dmpl_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic mem_writable = 1'b0;
  dmpl_req_t usr_req = '0;
  dmpl_sys_t sys_in = '0;
  logic psel, penable, pwrite, pready, pslverr, usr_ready, sys_ready;
  logic applied, cs_flag, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, w;
  logic [15:0] sum;
  logic [7:0] alarm;
  dmpl_rsp_t usr_rsp;
  dmpl_settings_t settings;
  int errors = 0;
  int compares = 0;
  // wr ind bop sop addr wdata err rdata
  dmpl_row_t rows [18] = '{
    '{1,0,0,0,11'h000,16'h1234,0,0}, '{0,0,0,0,11'h000,0,0,16'h1234},
    '{1,0,0,0,11'h383,16'ha5a5,0,0}, '{0,0,0,0,11'h383,0,0,16'ha5a5},
    '{0,0,0,0,11'h3e8,0,0,16'h5a5a}, '{1,0,0,0,11'h76b,16'h1111,1,0},
    '{0,0,1,0,11'h000,0,1,0}, '{1,0,0,1,11'h000,16'h0,1,0},
    '{0,0,0,0,11'h7d0,0,1,0}, '{1,0,0,0,11'h064,16'h0324,0,0},
    '{1,0,0,0,11'h144,16'hbeef,0,0}, '{0,1,0,0,11'h064,0,0,16'hbeef},
    '{1,1,0,0,11'h064,16'h0042,0,0}, '{0,0,0,0,11'h144,0,0,16'h0042},
    '{1,0,0,0,11'h064,16'h1500,0,0}, '{1,1,0,0,11'h064,16'h7777,1,0},
    '{1,0,0,0,11'h064,16'h12ab,0,0}, '{0,1,0,0,11'h064,0,1,0}};
  always #10 clk = ~clk;
  dmpl_loader dmpl_loader_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usr_req(usr_req), .usr_ready(usr_ready), .usr_rsp(usr_rsp),
    .set_system_instruction(sys_in), .sys_ready(sys_ready),
    .mem_writable(mem_writable), .settings(settings),
    .settings_applied(applied), .parameter_checksum_error_flag(cs_flag),
    .failure_alarm_code(alarm), .busy(busy));
  dmpl_prog_dev dmpl_prog_dev_inst (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ========
  // Helpers
  function automatic logic [15:0] pv(int i);
    return {(i % 4 == 3) ? 8'h07 : 8'h01, 8'(i + 16)};
  endfunction
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rg(logic wr, logic [11:0] a, logic [31:0] d);
    dmpl_prog_dev_inst.xfer(wr, a, d, w, e);
  endtask
  task automatic dm_wr(int i, logic [15:0] v);
    rg(1'b1, REG_DM_ADDR, 32'(i));
    rg(1'b1, REG_DM_DATA, {16'h0000, v});
  endtask
  task automatic dm_rd(int i);
    rg(1'b1, REG_DM_ADDR, 32'(i));
    rg(1'b0, REG_DM_DATA, 32'h0);
  endtask
  // Two edges first so a start that lands late is not missed
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    chk("idle", 32'h0, {31'h0, busy});
  endtask
  task automatic sys_cmd(logic [3:0] c);
    @(posedge clk);
    sys_in <= {1'b1, c};
    do @(negedge clk); while (sys_ready !== 1'b1);
    @(posedge clk);
    sys_in <= '0;
    wait_idle();
  endtask
  task automatic usr_op(dmpl_row_t r);
    @(posedge clk);
    usr_req <= {1'b1, r.wr, r.ind, r.bop, r.sop, r.addr, r.wd};
    do @(negedge clk); while (usr_ready !== 1'b1);
    @(posedge clk);
    usr_req <= {5'h00, ~r.addr, ~r.wd};
    @(negedge clk);
    chk("done", 32'h1, {31'h0, usr_rsp.done});
    chk("error", {31'h0, r.err}, {31'h0, usr_rsp.error});
    if (!r.err && !r.wr) chk("rdata", {16'h0, r.rd}, {16'h0, usr_rsp.rdata});
  endtask
  task automatic chk_set(logic dflt);
    logic [15:0] v;
    for (int i = 0; i < 30; i++) begin
      v = pv(i);
      if (dflt || v[15:8] > 8'h02) v = 16'h0;
      chk("setting", {16'h0, v}, {16'h0, settings[i]});
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1600000;
    errors++;
    close_out();
  end
  // ========
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle();
    rg(1'b1, REG_STAT, 32'h4);
    dm_wr(1000, 16'h5a5a);
    foreach (rows[i]) usr_op(rows[i]);
    $display("test operand_port done");
    sum = 16'h0;
    for (int i = 0; i < 30; i++) begin
      dm_wr(900 + i, pv(i));
      sum += pv(i);
    end
    dmpl_prog_dev_inst.run_cmd(CMD_APPLY, w);
    chk("cmd_word", 32'h8180, w);
    chk_set(1'b0);
    dm_rd(930);
    chk("param_sum", {16'h0, sum}, w);
    dmpl_prog_dev_inst.run_cmd(CMD_BACKUP, w);
    chk("cmd_word", 32'h8240, w);
    mem_writable <= 1'b1;
    sys_cmd(CMD_BACKUP);
    rg(1'b0, REG_STAT, 32'h0);
    chk("bk_valid", 32'h1, {31'h0, w[STAT_BKVALID]});
    chk("failed", 32'h0, {31'h0, w[STAT_LASTFAIL]});
    dm_rd(1930);
    chk("backup_sum", {16'h0, sum}, w);
    sys_cmd(CMD_CLEAR);
    for (int i = 0; i < 30; i++) begin
      dm_rd(900 + i);
      chk("param_clear", 32'h0, w);
      dm_rd(1900 + i);
      chk("backup", {16'h0, pv(i)}, w);
    end
    sys_cmd(CMD_RELOAD);
    dm_rd(905);
    chk("restored", {16'h0, pv(5)}, w);
    chk_set(1'b0);
    chk("cs_flag", 32'h0, {31'h0, cs_flag});
    $display("test parameters done");
    dm_wr(1900, 16'hffff);
    chk("bk_refused", 32'h1, {31'h0, e});
    rg(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    sys_cmd(CMD_DISABLE);
    rg(1'b0, REG_STAT, 32'h0);
    chk("bk_valid", 32'h0, {31'h0, w[STAT_BKVALID]});
    rg(1'b1, REG_CLEAR, 32'h1);
    wait_idle();
    dm_rd(1000);
    chk("cleared", 32'h0, w);
    dm_rd(905);
    chk("sys_kept", {16'h0, pv(5)}, w);
    dm_rd(1900);
    chk("bk_kept", {16'h0, pv(0)}, w);
    dm_wr(905, 16'h0);
    dmpl_prog_dev_inst.run_cmd(CMD_RESTORE, w);
    chk("cmd_word", 32'h8680, w);
    dm_rd(905);
    chk("copied", {16'h0, pv(5)}, w);
    dm_wr(930, 16'h0);
    dmpl_prog_dev_inst.run_cmd(CMD_RESUM, w);
    chk("cmd_word", 32'h8780, w);
    dm_rd(930);
    chk("resum", {16'h0, sum}, w);
    $display("test commands done");
    dm_wr(905, 16'h0);
    sys_cmd(CMD_RELOAD);
    chk("cs_flag", 32'h1, {31'h0, cs_flag});
    chk("alarm", 32'h9f, {24'h0, alarm});
    chk_set(1'b1);
    rg(1'b0, REG_STAT, 32'h0);
    chk("stat", 32'h9f04, w & 32'hff04);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    clk_en <= 1'b0;
    repeat (200) @(posedge clk);
    chk("frozen", 32'h1, {31'h0, busy});
    clk_en <= 1'b1;
    wait_idle();
    dm_rd(1900);
    chk("retained", {16'h0, pv(0)}, w);
    chk("cs_flag", 32'h1, {31'h0, cs_flag});
    $display("test reset done");
    close_out();
  end
endmodule // tb
